// *** dew_ctrl.sv ***
// data eeprom access and row programming controller with axi4-lite csr
//
// Contract
// - read mode returns array byte same cycle
// - write mode latches bus writes by address
// - program start programs all latched bytes
// - row comes from latest latched write
// - cycle end clears both bits, raises irq if ie set
// - vector fetch clears pending completion irq
// - latches cleared at end, wbm fall; and-combine
// - latched data cannot be read back
// - sleep waits for programming to finish
// - halt abandons any operation at once
// - read in write mode leaves bus undriven
// - writes in read mode are not latched
// - interrupted cycle leaves row unguaranteed
// - csr resets zero, bits 7:3 read zero
// - irq enable written any cycle but the commit cycle, gates completion
// - wbm cleared by software only when idle
// - program start reads one while busy
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "dew_cfg.svh"
module dew_ctrl #(
  parameter int ERASE_CYCLES = `DEW_ERASE_CYC,
  parameter int WRITE_CYCLES = `DEW_WRITE_CYC,
  parameter int MEM_BYTES = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dew_pkg::dew_axi_req_t axi_req,
  output dew_pkg::dew_axi_rsp_t axi_rsp,
  input wire dew_pkg::dew_mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  output logic mem_rdata_oe_n,
  input wire logic sleep_instruction,
  input wire logic halt_instruction,
  input wire logic wake,
  input wire logic irq_vector_fetch,
  output logic done_irq,
  output logic busy,
  output logic wait_mode,
  output logic halt_mode
);
  // ********************************************************
  // decode helpers
  // ********************************************************
  // csr hit, used by both the write and the read path
  function automatic logic is_csr(input logic [`DEW_AXI_AW-1:0] a);
    is_csr = (a == `DEW_CSR_OFF);
  endfunction

  // ********************************************************
  // axi4-lite slave
  // ********************************************************
  logic aw_held_q, aw_held_d; // write address taken, waiting for data
  logic w_held_q, w_held_d; // write data taken, waiting for address
  logic [`DEW_AXI_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire; // both halves present, commit this cycle
  logic csr_wr; // low byte of the csr written
  logic [7:0] csr_view; // csr as software sees it
  // control state, declared here since the read path shows it
  logic ie_q, ie_d;
  logic wbm_q, wbm_d;
  logic pgm_q, pgm_d;

  // accept one write and one read at a time
  assign axi_rsp.awready = !aw_held_q && !bvalid_q;
  assign axi_rsp.wready = !w_held_q && !bvalid_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign csr_wr = wr_fire && is_csr(awaddr_q) && wstrb_q[0];
  // reserved bits 7:3 always read zero
  assign csr_view = {5'h00, ie_q, wbm_q, pgm_q};

  // next state of the bus slave
  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    // address and data may arrive in either order
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      aw_held_d = 1'b1;
      awaddr_d = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      w_held_d = 1'b1;
      wdata_d = axi_req.wdata;
      wstrb_d = axi_req.wstrb;
    end
    // response once both halves are held
    if (wr_fire)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_csr(awaddr_q) ? `DEW_RESP_OKAY : `DEW_RESP_SLVERR;
    end
    else if (bvalid_q && axi_req.bready)
    begin
      bvalid_d = 1'b0;
    end
    // reads answer the cycle after the address is taken
    if (axi_req.arvalid && axi_rsp.arready)
    begin
      rvalid_d = 1'b1;
      rdata_d = is_csr(axi_req.araddr) ? {24'h000000, csr_view} : 32'h0;
      rresp_d = is_csr(axi_req.araddr) ? `DEW_RESP_OKAY : `DEW_RESP_SLVERR;
    end
    else if (rvalid_q && axi_req.rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  // register the bus slave
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `DEW_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `DEW_RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ********************************************************
  // control register, sequencer, irq and power modes
  // ********************************************************
  localparam logic [31:0] ERASE_LAST = 32'(ERASE_CYCLES - 1);
  localparam logic [31:0] WRITE_LAST = 32'(WRITE_CYCLES - 1);
  dew_pkg::dew_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d; // cycles left in the current phase
  logic irq_q, irq_d; // pending completion request
  logic wpend_q, wpend_d; // sleep seen while programming
  logic wait_q, wait_d;
  logic halt_q, halt_d;
  logic commit; // one-cycle pulse at the end of the write phase

  // next state of the control group
  always_comb
  begin
    ie_d = ie_q;
    wbm_d = wbm_q;
    pgm_d = pgm_q;
    state_d = state_q;
    cnt_d = cnt_q;
    irq_d = irq_q;
    wpend_d = wpend_q;
    wait_d = wait_q;
    halt_d = halt_q;
    commit = 1'b0;
    // timed phases: erase chained into write
    case (state_q)
      dew_pkg::ST_ERASE:
      begin
        if (cnt_q == 32'h0)
        begin
          state_d = dew_pkg::ST_WRITE;
          cnt_d = WRITE_LAST;
        end
        else
          cnt_d = cnt_q - 32'h1;
      end
      dew_pkg::ST_WRITE:
      begin
        if (cnt_q == 32'h0)
        begin
          commit = 1'b1;
          state_d = dew_pkg::ST_IDLE;
          pgm_d = 1'b0;
          wbm_d = 1'b0;
        end
        else
          cnt_d = cnt_q - 32'h1;
      end
      default:
        cnt_d = cnt_q;
    endcase
    // software access; hardware end still wins below
    if (csr_wr && !commit)
    begin
      ie_d = wdata_q[`DEW_BIT_IE];
      if (wdata_q[`DEW_BIT_WBM])
        wbm_d = 1'b1;
      else if (!pgm_q)
        wbm_d = 1'b0;
      if (wdata_q[`DEW_BIT_PGM] && !pgm_q)
      begin
        pgm_d = 1'b1;
        state_d = dew_pkg::ST_ERASE;
        cnt_d = ERASE_LAST;
      end
      else if (!wdata_q[`DEW_BIT_PGM] && pgm_q)
      begin
        // abort: row left partly programmed
        pgm_d = 1'b0;
        state_d = dew_pkg::ST_IDLE;
      end
    end
    // pending request: a new completion beats the vector clear
    if (irq_vector_fetch)
      irq_d = 1'b0;
    if (commit && ie_q)
      irq_d = 1'b1;
    // wake releases both low power modes
    if (wake)
    begin
      wait_d = 1'b0;
      halt_d = 1'b0;
    end
    // wait only once the sequencer is idle
    if (sleep_instruction)
      wpend_d = 1'b1;
    if ((sleep_instruction || wpend_q) && state_d == dew_pkg::ST_IDLE)
    begin
      wait_d = 1'b1;
      wpend_d = 1'b0;
    end
    // halt drops the programming cycle and its commit, keeps a pending irq; data in flight may be corrupt
    if (halt_instruction)
    begin
      halt_d = 1'b1;
      state_d = dew_pkg::ST_IDLE;
      pgm_d = 1'b0;
      commit = 1'b0;
      irq_d = irq_q && !irq_vector_fetch;
    end
  end

  // register the control group
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ie_q <= 1'b0;
      wbm_q <= 1'b0;
      pgm_q <= 1'b0;
      state_q <= dew_pkg::ST_IDLE;
      cnt_q <= 32'h0;
      irq_q <= 1'b0;
      wpend_q <= 1'b0;
      wait_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      ie_q <= ie_d;
      wbm_q <= wbm_d;
      pgm_q <= pgm_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      irq_q <= irq_d;
      wpend_q <= wpend_d;
      wait_q <= wait_d;
      halt_q <= halt_d;
    end
  end

  assign done_irq = irq_q;
  assign busy = pgm_q;
  assign wait_mode = wait_q;
  assign halt_mode = halt_q;

  // ********************************************************
  // data latches and array
  // ********************************************************
  localparam int LW = $clog2(`DEW_LATCHES);
  logic [7:0] mem_q [MEM_BYTES]; // nonvolatile cells, no reset
  logic [7:0] latch_q [`DEW_LATCHES];
  logic [7:0] latch_d [`DEW_LATCHES];
  logic [`DEW_LATCHES-1:0] lval_q, lval_d; // byte captured since clear
  logic [`DEW_MEM_AW-LW-1:0] row_q, row_d;
  logic lat_wr; // bus write captured into a latch
  logic lat_clr; // end of cycle or falling write mode

  // capture only in write mode and outside a cycle
  assign lat_wr = mem_req.sel && mem_req.we && wbm_q && !pgm_q;
  assign lat_clr = commit || (wbm_q && !wbm_d);
  assign row_d = lat_wr ? mem_req.addr[`DEW_MEM_AW-1:LW] : row_q;

  // one lane per latch byte
  for (genvar i = 0; i < `DEW_LATCHES; i++)
  begin : g_lane
    always_comb
    begin
      latch_d[i] = latch_q[i];
      lval_d[i] = lval_q[i];
      if (lat_clr)
      begin
        latch_d[i] = 8'hFF;
        lval_d[i] = 1'b0;
      end
      else if (lat_wr && mem_req.addr[LW-1:0] == LW'(i))
      begin
        // repeated writes over-program, never restore bits
        latch_d[i] = latch_q[i] & mem_req.wdata;
        lval_d[i] = 1'b1;
      end
    end
  end

  // register latches, row and the array itself
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int k = 0; k < `DEW_LATCHES; k++)
        latch_q[k] <= 8'hFF;
      lval_q <= '0;
      row_q <= '0;
    end
    else
    begin
      for (int k = 0; k < `DEW_LATCHES; k++)
        latch_q[k] <= latch_d[k];
      lval_q <= lval_d;
      row_q <= row_d;
    end
    // cells keep their value through reset
    if (commit)
      for (int k = 0; k < `DEW_LATCHES; k++)
        if (lval_q[k])
          mem_q[{row_q, LW'(k)}] <= latch_q[k];
  end

  // array read path only; latches have no read path at all
  assign mem_rdata = wbm_q ? 8'h00 : mem_q[mem_req.addr];
  assign mem_rdata_oe_n = !(mem_req.sel && !mem_req.we && !wbm_q);
endmodule

// *** dew_cfg.svh ***
// offsets, field positions, reset values and timing counts
`ifndef DEW_CFG_SVH
`define DEW_CFG_SVH
`define DEW_AXI_AW 12
`define DEW_MEM_AW 8
`define DEW_CSR_OFF 12'h02C
`define DEW_CSR_RESET 8'h00
`define DEW_BIT_IE 2
`define DEW_BIT_WBM 1
`define DEW_BIT_PGM 0
`define DEW_LATCHES 16
`define DEW_CLK_MHZ 50
`define DEW_ERASE_US 2000
`define DEW_WRITE_US 2000
`define DEW_ERASE_CYC (`DEW_ERASE_US * `DEW_CLK_MHZ)
`define DEW_WRITE_CYC (`DEW_WRITE_US * `DEW_CLK_MHZ)
`define DEW_RESP_OKAY 2'h0
`define DEW_RESP_SLVERR 2'h2
`endif

// *** dew_pkg.sv ***
// types shared by the data eeprom write controller
`include "dew_cfg.svh"
package dew_pkg;
  // programming sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} dew_state_t;
  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [`DEW_AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`DEW_AXI_AW-1:0] araddr;
    logic rready;
  } dew_axi_req_t;
  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dew_axi_rsp_t;
  // processor data bus access to the eeprom area
  typedef struct packed {
    logic sel;
    logic we;
    logic [`DEW_MEM_AW-1:0] addr;
    logic [7:0] wdata;
  } dew_mem_req_t;
endpackage

// *** dew_ctrl_props.sv ***
// checker for the data eeprom controller ports
`timescale 1ns/100ps
module dew_ctrl_props #(
  parameter int ERASE_CYCLES = 4,
  parameter int WRITE_CYCLES = 4,
  parameter int MEM_BYTES = 256
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dew_pkg::dew_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rdata_oe_n,
  input wire logic sleep_instruction,
  input wire logic halt_instruction,
  input wire logic wake,
  input wire logic irq_vector_fetch,
  input wire logic done_irq,
  input wire logic busy,
  input wire logic wait_mode,
  input wire logic halt_mode
);
  // the commit edge is the last write edge, so no extra cycle
  localparam int TOT = ERASE_CYCLES + WRITE_CYCLES;
  logic [31:0] cnt_q; // busy cycles so far
  logic [31:0] cnt_d;
  // count the length of each programming cycle
  always_comb cnt_d = busy ? cnt_q + 32'h1 : 32'h0;
  always_ff @(posedge aclk)
    cnt_q <= aresetn ? cnt_d : 32'h0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_oe_read; !mem_rdata_oe_n |-> mem_req.sel && !mem_req.we;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("bus driven");
  property p_oe_off; mem_req.sel && !mem_req.we && mem_rdata_oe_n
    |-> mem_rdata == 8'h00; endproperty
  a_oe_off: assert property (p_oe_off) else $error("read leak");
  property p_irq_end; $rose(done_irq) |-> $fell(busy); endproperty
  a_irq_end: assert property (p_irq_end) else $error("irq early");
  property p_cyc_len; $rose(done_irq) |-> cnt_q == TOT; endproperty
  a_cyc_len: assert property (p_cyc_len) else $error("cycle len");
  property p_irq_clr; irq_vector_fetch && !busy |=> !done_irq; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq kept");
  property p_irq_hold; done_irq && !irq_vector_fetch |=> done_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
  property p_halt; halt_instruction && !wake |=> halt_mode && !busy;
  endproperty
  a_halt: assert property (p_halt) else $error("halt late");
  property p_wait_idle; sleep_instruction && !busy && !wake |=> wait_mode;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("no wait");
  property p_wait_busy; $rose(wait_mode) |-> !busy; endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("wait busy");
endmodule
bind dew_ctrl dew_ctrl_props #(.ERASE_CYCLES(ERASE_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES), .MEM_BYTES(MEM_BYTES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .mem_rdata_oe_n(mem_rdata_oe_n),
  .sleep_instruction(sleep_instruction),
  .halt_instruction(halt_instruction), .wake(wake),
  .irq_vector_fetch(irq_vector_fetch), .done_irq(done_irq),
  .busy(busy), .wait_mode(wait_mode), .halt_mode(halt_mode));

// *** dew_cpu_model.sv ***
// processor model: byte port accesses and event pulses
`timescale 1ns/100ps
module dew_cpu_model (
  input wire logic aclk,
  output dew_pkg::dew_mem_req_t mem_req,
  output logic [3:0] ev, // sleep, halt, wake, vector fetch
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rdata_oe_n
);
  initial
  begin
    mem_req <= '0;
    ev <= 4'h0;
  end
  // idle bus shows inverted values, so nothing stale can pass
  task automatic idle_bus();
    mem_req.sel <= 1'b0;
    mem_req.addr <= ~mem_req.addr;
    mem_req.wdata <= ~mem_req.wdata;
  endtask
  // data accesses only, never an instruction fetch
  task automatic mem_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    mem_req <= '{sel: 1'b1, we: 1'b1, addr: a, wdata: d};
    @(posedge aclk);
    idle_bus();
  endtask
  // read answer is taken at the edge closing the access
  task automatic mem_read(input logic [7:0] a, output logic [8:0] r);
    @(posedge aclk);
    mem_req <= '{sel: 1'b1, we: 1'b0, addr: a, wdata: 8'h00};
    @(posedge aclk);
    r = {mem_rdata_oe_n, mem_rdata};
    idle_bus();
  endtask
  task automatic pulse(input int k);
    @(posedge aclk);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
  endtask
endmodule

// *** testbench.sv ***
// register and byte port tests of the data eeprom controller
`timescale 1ns/100ps
`include "dew_cfg.svh"
module testbench;
  localparam logic [11:0] CSR = `DEW_CSR_OFF;
  localparam logic [1:0] OK = `DEW_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn;
  dew_pkg::dew_axi_req_t req;
  dew_pkg::dew_axi_rsp_t rsp;
  dew_pkg::dew_mem_req_t mreq;
  logic [7:0] mrd;
  logic moe_n, irq, busy, wmode, hmode;
  logic [3:0] ev;
  logic [8:0] r;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #10 aclk = ~aclk;
  dew_ctrl #(.ERASE_CYCLES(4), .WRITE_CYCLES(20)) u_dew_ctrl (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .mem_req(mreq), .mem_rdata(mrd), .mem_rdata_oe_n(moe_n),
    .sleep_instruction(ev[0]), .halt_instruction(ev[1]), .wake(ev[2]),
    .irq_vector_fetch(ev[3]), .done_irq(irq), .busy(busy),
    .wait_mode(wmode), .halt_mode(hmode));
  dew_cpu_model u_cpu (.aclk(aclk), .mem_req(mreq), .ev(ev),
    .mem_rdata(mrd), .mem_rdata_oe_n(moe_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard: the whole run needs well under this many cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && rsp.awready)
      begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready)
      begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!rsp.bvalid);
    chk(rsp.bresp, er);
    req.bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (!rsp.rvalid);
    chk({rsp.rresp, rsp.rdata}, {er, ed});
    req.rready <= 1'b0;
  endtask
  // wait for the programming cycle to finish, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy && n < 200)
    begin
      @(posedge aclk);
      n++;
    end
    chk(busy, 1'b0);
  endtask
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    u_cpu.mem_read(a, r);
    chk(r, {1'b0, e});
  endtask
  initial
  begin
    aresetn <= 1'b0;
    req <= '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(CSR, 32'h0, OK);
    axi_wr(CSR, 32'hFFFFFFFE, OK);
    axi_rd(CSR, 32'h6, OK);
    axi_rd(12'h030, 32'h0, `DEW_RESP_SLVERR);
    axi_wr(12'h030, 32'h0, `DEW_RESP_SLVERR);
    u_cpu.mem_write(8'h35, 8'hA5);
    u_cpu.mem_write(8'h35, 8'h0F);
    u_cpu.mem_write(8'h36, 8'h11);
    u_cpu.mem_write(8'h3F, 8'h77);
    u_cpu.mem_read(8'h35, r);
    chk(r, 9'h100);
    axi_wr(CSR, 32'h7, OK);
    axi_rd(CSR, 32'h7, OK);
    u_cpu.pulse(0);
    chk(wmode, 1'b0);
    wait_idle();
    chk({irq, wmode}, 2'b11);
    axi_rd(CSR, 32'h4, OK);
    rdb(8'h35, 8'h05);
    rdb(8'h36, 8'h11);
    rdb(8'h3F, 8'h77);
    u_cpu.pulse(2);
    u_cpu.pulse(3);
    @(posedge aclk);
    chk(irq, 1'b0);
    u_cpu.mem_write(8'h35, 8'h00);
    axi_wr(CSR, 32'h6, OK);
    u_cpu.mem_write(8'h36, 8'h00);
    axi_wr(CSR, 32'h4, OK);
    axi_wr(CSR, 32'h6, OK);
    u_cpu.mem_write(8'h37, 8'h3C);
    axi_wr(CSR, 32'h7, OK);
    wait_idle();
    rdb(8'h35, 8'h05);
    rdb(8'h36, 8'h11);
    rdb(8'h37, 8'h3C);
    u_cpu.pulse(3);
    axi_wr(CSR, 32'h6, OK);
    u_cpu.mem_write(8'h38, 8'hAA);
    axi_wr(CSR, 32'h7, OK);
    u_cpu.pulse(1);
    @(posedge aclk);
    chk({hmode, busy, irq}, 3'b100);
    axi_rd(CSR, 32'h6, OK);
    u_cpu.pulse(2);
    axi_wr(CSR, 32'h3, OK);
    axi_wr(CSR, 32'h1, OK);
    axi_rd(CSR, 32'h3, OK);
    wait_idle();
    chk(irq, 1'b0);
    axi_rd(CSR, 32'h0, OK);
    u_cpu.pulse(0);
    @(posedge aclk);
    chk(wmode, 1'b1);
    // reset in mid-cycle: csr and status outputs back to zero
    axi_wr(CSR, 32'h7, OK);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(CSR, 32'h0, OK);
    chk({irq, busy, wmode, hmode}, 4'h0);
    give_verdict();
  end
endmodule
